/* sbg_baud_gen.sv */
/*
 * Baud rate generator of one serial interface with its divisor, enable,
 * interrupt enable and event flag registers behind an AXI4-Lite slave.
 * Assumes the receiver logic delivers break and active-edge events as
 * one-cycle pulses on the bus clock, and that the bus is AXI4-Lite.
 */
//
// What this block does
// - Divisor zero stops the generator entirely to save current.
// - Divisor bits of the high byte are buffered until the low byte is written.
// - Low byte resets nonzero; generator idle until first enable write.
// - Divisor bits 12:8 sit in high bits 4:0, bits 7:0 in low.
// - High bit 7 enables interrupt from the break detect flag.
// - High bit 6 enables interrupt from the receive edge flag.
// - Transmitter and receiver share this instance's own single baud rate.
`timescale 1ns/100ps
module sbg_baud_gen (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    input  wire logic        i_break_detect_evt,
    input  wire logic        i_rx_edge_evt,
    output logic             o_baud_tick,
    output logic             o_bit_tick,
    output logic             o_gen_active,
    output logic             o_receiver_enable,
    output logic             o_transmitter_enable,
    output logic             o_irq
);

    localparam int DW = sbg_pkg::DIV_W;

    function automatic sbg_pkg::sbg_reg_t decode(input logic [7:0] addr);
        sbg_pkg::sbg_reg_t sel;
        if (addr == sbg_pkg::OFF_BDH) begin
            sel = sbg_pkg::SBG_REG_BDH;
        end else if (addr == sbg_pkg::OFF_BDL) begin
            sel = sbg_pkg::SBG_REG_BDL;
        end else if (addr == sbg_pkg::OFF_CTRL) begin
            sel = sbg_pkg::SBG_REG_CTRL;
        end else if (addr == sbg_pkg::OFF_STAT) begin
            sel = sbg_pkg::SBG_REG_STAT;
        end else begin
            sel = sbg_pkg::SBG_REG_NONE;
        end
        return sel;
    endfunction

    // Held write request.
    logic [7:0]               aw_addr;
    logic [7:0]               w_data;
    logic                     w_lane0;

    // Register state.
    logic [sbg_pkg::HI_MSB:0] div_hi_buf;
    logic [DW-1:0]            baud_divisor_value;
    logic                     break_detect_irq_enable;
    logic                     rx_edge_irq_enable;
    logic                     started;
    logic                     break_detect_flag;
    logic                     rx_edge_flag;
    logic [sbg_pkg::OVS_W-1:0] ovs_count;

    // Decoded register selects, write strobes and read byte.
    sbg_pkg::sbg_reg_t        wr_sel;
    sbg_pkg::sbg_reg_t        rd_sel;
    logic                     do_write;
    logic                     wr_hit;
    logic                     bdh_wr;
    logic                     bdl_wr;
    logic                     ctrl_wr;
    logic                     stat_wr;
    logic [7:0]               rd_byte;

    sbg_div_if div_bus ();

    // Both halves of a write are held once both readies have dropped.
    assign do_write = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
    assign wr_sel   = decode(aw_addr);
    assign rd_sel   = decode(i_s_axi_araddr);
    assign wr_hit   = do_write && w_lane0;
    assign bdh_wr   = wr_hit && (wr_sel == sbg_pkg::SBG_REG_BDH);
    assign bdl_wr   = wr_hit && (wr_sel == sbg_pkg::SBG_REG_BDL);
    assign ctrl_wr  = wr_hit && (wr_sel == sbg_pkg::SBG_REG_CTRL);
    assign stat_wr  = wr_hit && (wr_sel == sbg_pkg::SBG_REG_STAT);

    // Write address channel.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_awready <= 1'b1;
            aw_addr         <= 8'h00;
        end else if (o_s_axi_awready && i_s_axi_awvalid) begin
            o_s_axi_awready <= 1'b0;
            aw_addr         <= i_s_axi_awaddr;
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_awready <= 1'b1;
        end
    end

    // Write data channel; only the low byte lane carries register data.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_wready <= 1'b1;
            w_data         <= 8'h00;
            w_lane0        <= 1'b0;
        end else if (o_s_axi_wready && i_s_axi_wvalid) begin
            o_s_axi_wready <= 1'b0;
            w_data         <= i_s_axi_wdata[7:0];
            w_lane0        <= i_s_axi_wstrb[0];
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_wready <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= sbg_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_s_axi_bvalid <= 1'b1;
            if (wr_sel == sbg_pkg::SBG_REG_NONE) begin
                o_s_axi_bresp <= sbg_pkg::RESP_SLVERR;
            end else begin
                o_s_axi_bresp <= sbg_pkg::RESP_OKAY;
            end
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // High divisor byte: enables take effect at once, divisor bits wait.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_hi_buf              <= sbg_pkg::BDH_RESET[sbg_pkg::HI_MSB:0];
            break_detect_irq_enable <= sbg_pkg::BDH_RESET[sbg_pkg::BRK_BIT];
            rx_edge_irq_enable      <= sbg_pkg::BDH_RESET[sbg_pkg::EDGE_BIT];
        end else if (bdh_wr) begin
            div_hi_buf              <= w_data[sbg_pkg::HI_MSB:0];
            break_detect_irq_enable <= w_data[sbg_pkg::BRK_BIT];
            rx_edge_irq_enable      <= w_data[sbg_pkg::EDGE_BIT];
        end
    end

    // The low byte write moves the buffered high bits into the divisor.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            baud_divisor_value <= {sbg_pkg::BDH_RESET[sbg_pkg::HI_MSB:0],
                                   sbg_pkg::BDL_RESET};
        end else if (bdl_wr) begin
            baud_divisor_value <= {div_hi_buf, w_data};
        end
    end

    // Receiver and transmitter enables; the first one written arms
    // the generator, which then stays armed.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_receiver_enable    <= sbg_pkg::CTRL_RESET[sbg_pkg::RE_BIT];
            o_transmitter_enable <= sbg_pkg::CTRL_RESET[sbg_pkg::TE_BIT];
            started              <= 1'b0;
        end else if (ctrl_wr) begin
            o_receiver_enable    <= w_data[sbg_pkg::RE_BIT];
            o_transmitter_enable <= w_data[sbg_pkg::TE_BIT];
            if (w_data[sbg_pkg::RE_BIT] || w_data[sbg_pkg::TE_BIT]) begin
                started <= 1'b1;
            end
        end
    end

    // Sticky event flags, cleared by writing one; a new event wins.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            break_detect_flag <= 1'b0;
            rx_edge_flag      <= 1'b0;
        end else begin
            break_detect_flag <= i_break_detect_evt | (break_detect_flag &
                ~(stat_wr & w_data[sbg_pkg::BRK_BIT]));
            rx_edge_flag      <= i_rx_edge_evt | (rx_edge_flag &
                ~(stat_wr & w_data[sbg_pkg::EDGE_BIT]));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (break_detect_flag & break_detect_irq_enable)
                   | (rx_edge_flag & rx_edge_irq_enable);
        end
    end

    // Generator runs only when armed and the divisor is nonzero.
    assign div_bus.run     = started
                           && (baud_divisor_value != 13'h0000);
    assign div_bus.divisor = baud_divisor_value;

    // One divider serves both the receiver and the transmitter.
    sbg_divider u_divider (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .div     (div_bus.gen)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gen_active <= 1'b0;
        end else begin
            o_gen_active <= div_bus.run;
        end
    end

    // The sixteen-times tick is passed on one cycle later.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_baud_tick <= 1'b0;
        end else begin
            o_baud_tick <= div_bus.tick;
        end
    end

    // Every sixteenth tick marks one bit time at the baud rate.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovs_count  <= 4'h0;
            o_bit_tick <= 1'b0;
        end else if (!div_bus.run) begin
            ovs_count  <= 4'h0;
            o_bit_tick <= 1'b0;
        end else begin
            o_bit_tick <= div_bus.tick
                          && (ovs_count == sbg_pkg::OVS_LAST);
            if (div_bus.tick) begin
                ovs_count <= ovs_count + 4'h1;
            end
        end
    end

    // Read data; unused and reserved bits read as zero.
    always_comb begin
        rd_byte = 8'h00;
        case (rd_sel)
            sbg_pkg::SBG_REG_BDH: begin
                rd_byte[sbg_pkg::BRK_BIT]    = break_detect_irq_enable;
                rd_byte[sbg_pkg::EDGE_BIT]   = rx_edge_irq_enable;
                rd_byte[sbg_pkg::HI_MSB:0]   = div_hi_buf;
            end
            sbg_pkg::SBG_REG_BDL: begin
                rd_byte = baud_divisor_value[7:0];
            end
            sbg_pkg::SBG_REG_CTRL: begin
                rd_byte[sbg_pkg::RE_BIT]     = o_receiver_enable;
                rd_byte[sbg_pkg::TE_BIT]     = o_transmitter_enable;
            end
            sbg_pkg::SBG_REG_STAT: begin
                rd_byte[sbg_pkg::BRK_BIT]    = break_detect_flag;
                rd_byte[sbg_pkg::EDGE_BIT]   = rx_edge_flag;
                rd_byte[sbg_pkg::RUN_BIT]    = o_gen_active;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Read channel: one read at a time, data one edge after the address.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h0000_0000;
            o_s_axi_rresp   <= sbg_pkg::RESP_OKAY;
        end else if (o_s_axi_arready && i_s_axi_arvalid) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b1;
            o_s_axi_rdata   <= {24'h00_0000, rd_byte};
            if (rd_sel == sbg_pkg::SBG_REG_NONE) begin
                o_s_axi_rresp <= sbg_pkg::RESP_SLVERR;
            end else begin
                o_s_axi_rresp <= sbg_pkg::RESP_OKAY;
            end
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid  <= 1'b0;
        end
    end

endmodule

/* sbg_baud_gen_props.sv */
/* Concurrent checks on the ports of the baud rate generator.
   Bound into sbg_baud_gen; one bus clock, asynchronous low reset. */
`timescale 1ns/100ps
module sbg_baud_gen_props (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic        i_break_detect_evt,
    input wire logic        i_rx_edge_evt,
    input wire logic        o_baud_tick,
    input wire logic        o_bit_tick,
    input wire logic        o_gen_active,
    input wire logic        o_receiver_enable,
    input wire logic        o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped early");
    chk_b_busy: assert property (o_s_axi_bvalid
        |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write ready during response");
    chk_wr_lat: assert property (i_s_axi_awvalid && o_s_axi_awready
        && i_s_axi_wvalid && o_s_axi_wready |=> ##[0:2] o_s_axi_bvalid)
        else $error("write response late");
    chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped early");
    chk_rd_lat: assert property (i_s_axi_arvalid && o_s_axi_arready
        |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read answer late");
    chk_gen_idle: assert property (!o_gen_active
        && !$past(o_gen_active) && !$past(o_gen_active, 2)
        |-> !o_baud_tick && !o_bit_tick)
        else $error("tick while generator idle");
    chk_en_arm: assert property ($rose(o_receiver_enable)
        |-> ##[0:2] o_gen_active)
        else $error("generator not started by enable");
    chk_bit_gap: assert property (o_bit_tick |=> !o_bit_tick [*8])
        else $error("bit ticks too close");
    chk_irq_cause: assert property ($rose(o_irq) |->
        $past(i_break_detect_evt, 2) || $past(i_rx_edge_evt, 2)
        || $past(i_break_detect_evt, 3) || $past(i_rx_edge_evt, 3)
        || $past(o_s_axi_bvalid) || $past(o_s_axi_bvalid, 2))
        else $error("interrupt without cause");
endmodule

bind sbg_baud_gen sbg_baud_gen_props u_props (
    .i_clk, .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
    .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rvalid, .i_s_axi_rready, .i_break_detect_evt, .i_rx_edge_evt,
    .o_baud_tick, .o_bit_tick, .o_gen_active, .o_receiver_enable, .o_irq
);

/* sbg_div_if.sv */
/*
 * Connection between the register side and the divider counter.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/100ps
interface sbg_div_if;
    logic [sbg_pkg::DIV_W-1:0] divisor;
    logic                      run;
    logic                      tick;

    modport ctrl (output divisor, output run, input tick);
    modport gen  (input divisor, input run, output tick);
endinterface

/* sbg_divider.sv */
/*
 * Modulo divider counter clocked by the bus clock; emits one tick per
 * divisor period as the sixteen-times oversampling clock.
 * Assumes the divisor is nonzero whenever run is high.
 */
`timescale 1ns/100ps
module sbg_divider (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    sbg_div_if.gen     div
);

    logic [sbg_pkg::DIV_W-1:0] count;
    logic                      at_end;

    // A lowered divisor below the current count ends the period at once.
    assign at_end = (count >= div.divisor);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= 13'h0001;
        end else if (!div.run) begin
            count <= 13'h0001;
        end else if (at_end) begin
            count <= 13'h0001;
        end else begin
            count <= count + 13'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div.tick <= 1'b0;
        end else begin
            div.tick <= div.run && at_end;
        end
    end

endmodule

/* sbg_evt_model.sv */
/* Far-side receiver model that reports line events to the generator.
   Assumes the same bus clock as the design; events last one cycle. */
`timescale 1ns/100ps
module sbg_evt_model (
    input  wire logic i_clk,
    output logic      o_break_evt,
    output logic      o_edge_evt
);
    initial begin
        o_break_evt = 1'h0;
        o_edge_evt = 1'h0;
    end
    task automatic pulse(input logic k);
        @(posedge i_clk);
        o_break_evt <= !k;
        o_edge_evt <= k;
        @(posedge i_clk);
        o_break_evt <= 1'h0;
        o_edge_evt <= 1'h0;
    endtask
endmodule

/* sbg_pkg.sv */
/*
 * Shared constants and types of the serial baud rate generator: register
 * offsets, field positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sbg_pkg;

    // Divisor width and oversampling ratio of the receiver and transmitter.
    localparam int          DIV_W      = 13;
    localparam int          OVS_W      = 4;
    localparam logic [3:0]  OVS_LAST   = 4'hF;

    // Register byte offsets.
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_BDH    = 8'h00;
    localparam logic [7:0]  OFF_BDL    = 8'h04;
    localparam logic [7:0]  OFF_CTRL   = 8'h08;
    localparam logic [7:0]  OFF_STAT   = 8'h0C;

    // Field positions in the high divisor byte and the status byte.
    localparam int          BRK_BIT    = 7;
    localparam int          EDGE_BIT   = 6;
    localparam int          HI_MSB     = 4;
    // Field positions in the control byte.
    localparam int          TE_BIT     = 3;
    localparam int          RE_BIT     = 2;
    // Read-only status bit that shows the generator running.
    localparam int          RUN_BIT    = 0;

    // Reset values; the low divisor byte resets to a nonzero value.
    localparam logic [7:0]  BDH_RESET  = 8'h00;
    localparam logic [7:0]  BDL_RESET  = 8'h04;
    localparam logic [7:0]  CTRL_RESET = 8'h00;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SBG_REG_BDH,
        SBG_REG_BDL,
        SBG_REG_CTRL,
        SBG_REG_STAT,
        SBG_REG_NONE
    } sbg_reg_t;

endpackage

/* tb_sbg_baud_gen.sv */
/* Self-checking bench of the baud rate generator over AXI4-Lite.
   Assumes the package offsets and a 100 MHz bus clock. */
`timescale 1ns/100ps
module tb_sbg_baud_gen;
    localparam logic [7:0] H = sbg_pkg::OFF_BDH;
    localparam logic [7:0] L = sbg_pkg::OFF_BDL;
    localparam logic [7:0] C = sbg_pkg::OFF_CTRL;
    localparam logic [7:0] S = sbg_pkg::OFF_STAT;
    localparam logic [1:0] OK = sbg_pkg::RESP_OKAY;
    localparam logic [1:0] SE = sbg_pkg::RESP_SLVERR;
    logic        i_clk = 1'h0, i_rst_n = 1'h0;
    logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, m;
    logic [3:0]  i_s_axi_wstrb = 4'hF;
    logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
    logic        i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0;
    logic        i_s_axi_rready = 1'h0;
    logic        slow = 1'h0;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic        o_s_axi_arready, o_s_axi_rvalid, o_baud_tick, o_bit_tick;
    logic        o_gen_active, o_receiver_enable, o_transmitter_enable;
    logic        o_irq, i_break_detect_evt, i_rx_edge_evt;
    int          errors = 0, n_tests = 0, cyc = 0, n;

    sbg_baud_gen dut (.*);
    sbg_evt_model u_model (
        .i_clk       (i_clk),
        .o_break_evt (i_break_detect_evt),
        .o_edge_evt  (i_rx_edge_evt)
    );

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end

    task summarize;
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        t = 0;
        @(posedge i_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid <= 1'h1;
        i_s_axi_bready <= !slow;
        do begin
            @(posedge i_clk);
            t++;
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
            if (o_s_axi_bvalid === 1'h1 && !i_s_axi_bready)
                i_s_axi_bready <= 1'h1;
        end while (!(o_s_axi_bvalid === 1'h1 && i_s_axi_bready === 1'h1)
                   && t < 50);
        i_s_axi_bready <= 1'h0;
        chk("bresp", {o_s_axi_bvalid, o_s_axi_bresp}, {1'h1, e});
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
        int t;
        t = 0;
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'h1;
        i_s_axi_rready <= !slow;
        do begin
            @(posedge i_clk);
            t++;
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
            if (o_s_axi_rvalid === 1'h1 && !i_s_axi_rready)
                i_s_axi_rready <= 1'h1;
        end while (!(o_s_axi_rvalid === 1'h1 && i_s_axi_rready === 1'h1)
                   && t < 50);
        i_s_axi_rready <= 1'h0;
        chk("rresp", {o_s_axi_rvalid, o_s_axi_rresp}, {1'h1, e});
        chk($sformatf("rdata at %h", a), o_s_axi_rdata, x);
    endtask

    // The first gap after a divisor change may be partial, so skip two and time the third.
    task period(input bit b, input int x, input string nm);
        for (int r = 0; r < 3; r++) begin
            n = 0;
            do begin
                @(posedge i_clk);
                n++;
            end while ((b ? o_bit_tick : o_baud_tick) !== 1'h1 && n < 9000);
        end
        chk(nm, n, x);
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'h1;
        rdc(H, 32'h00, OK);
        rdc(L, 32'h04, OK);
        rdc(C, 32'h00, OK);
        rdc(S, 32'h00, OK);
        rdc(8'h40, 32'h00, SE);
        wr(8'h40, 32'hFF, SE);
        repeat (20) @(posedge i_clk);
        chk("active", o_gen_active, 1'h0);
        wr(C, 32'h04, OK);
        chk("rx enable", o_receiver_enable, 1'h1);
        repeat (3) @(posedge i_clk);
        chk("active", o_gen_active, 1'h1);
        period(0, 4, "baud");
        period(1, 64, "bit");
        wr(H, 32'h01, OK);
        period(0, 4, "baud");
        wr(L, 32'h02, OK);
        period(0, 258, "baud");
        period(1, 4128, "bit");
        rdc(L, 32'h02, OK);
        i_s_axi_wstrb <= 4'hE;
        wr(L, 32'h07, OK);
        i_s_axi_wstrb <= 4'hF;
        rdc(L, 32'h02, OK);
        slow = 1'h1;
        wr(H, 32'hFF, OK);
        rdc(H, 32'hDF, OK);
        slow = 1'h0;
        wr(H, 32'h00, OK);
        wr(L, 32'h01, OK);
        period(0, 1, "baud");
        period(1, 16, "bit");
        for (int b = 0; b < 2; b++) begin
            m = b ? 32'h40 : 32'h80;
            u_model.pulse(b[0]);
            repeat (3) @(posedge i_clk);
            chk("irq", o_irq, 1'h0);
            rdc(S, m | 32'h01, OK);
            wr(H, m, OK);
            repeat (2) @(posedge i_clk);
            chk("irq", o_irq, 1'h1);
            wr(S, m, OK);
            repeat (2) @(posedge i_clk);
            chk("irq", o_irq, 1'h0);
            wr(H, 32'h00, OK);
        end
        wr(L, 32'h00, OK);
        repeat (4) @(posedge i_clk);
        chk("active", o_gen_active, 1'h0);
        n = 0;
        repeat (200) begin
            @(posedge i_clk);
            if (o_baud_tick !== 1'h0 || o_bit_tick !== 1'h0) n++;
        end
        chk("ticks", n, 0);
        rdc(S, 32'h00, OK);
        wr(C, 32'h08, OK);
        repeat (2) @(posedge i_clk);
        chk("tx enable", o_transmitter_enable, 1'h1);
        chk("rx enable", o_receiver_enable, 1'h0);
        chk("active", o_gen_active, 1'h0);
        rdc(C, 32'h08, OK);
        summarize();
    end
endmodule
